// ==== inc/ccs_pkg.sv ====
package ccs_pkg;

  // =====================================================================
  // serial port
  // =====================================================================
  localparam logic [6:0] SLAVE_ADDR    = 7'h6a;
  localparam logic [1:0] CMD_WRITE     = 2'h0;
  localparam logic [1:0] CMD_SAVE      = 2'h1;
  localparam logic [1:0] CMD_RESTORE   = 2'h2;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam logic [7:0] ID_BYTE_RESET = 8'h5a;  // arbitrary value

  // =====================================================================
  // register map
  // =====================================================================
  localparam logic [7:0] REG_POLARITY   = 8'h02;
  localparam int         POLARITY_BIT   = 0;
  localparam logic [7:0] REG_OUT_ACTIVE = 8'h03;
  localparam logic [7:0] REG_OUT_GATE   = 8'h04;
  localparam logic [7:0] REG_CFG_BASE   = 8'h10;
  localparam logic [2:0] NUM_CONFIGS    = 3'h6;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // =====================================================================
  // switchover modes
  // =====================================================================
  localparam logic [1:0] MODE_AUTO   = 2'h2;
  localparam logic [1:0] MODE_REVERT = 2'h3;

  // =====================================================================
  // types
  // =====================================================================
  typedef enum logic [2:0] {
    PH_ADDR, PH_CMD, PH_REG, PH_WDATA, PH_RDATA, PH_HOLD, PH_IGNORE
  } ccs_phase_e;

  typedef enum logic [1:0] {NV_IDLE, NV_SAVE, NV_RESTORE} ccs_nvm_e;

  typedef struct packed {
    ccs_phase_e  kind;
    logic [7:0]  data;
  } ccs_evt_s;

  typedef struct packed {
    logic [2:0]  spare;
    logic        shutdown_function;
    logic [1:0]  switchover_mode;
    logic        primary_source_select;
    logic        crystal_bypass;
  } ccs_cfg_s;

endpackage

// ==== logic/ccs_ctrl.sv ====
`timescale 1ns/100ps

// Behaviour
// - select pins 0..5 choose stored set
// - source select bit and pin pick reference
// - bypass bit skips crystal oscillator
// - mode field: manual, auto, auto-revertive
// - polarity bit: pin low-active for gated outputs when 1
// - shutdown bit: pin stops PLLs or gates outputs
// - inactive output hi-z except in global shutdown; gated output suspends on pin
// - shutdown bit and pin high suspend all
// - answer only slave address 1101010
// - write frame: address, command 00, register, data
// - register pointer increments after each data byte
// - read returns id byte then registers until nack
// - command 01 saves registers to non-volatile store
// - command 10 restores registers from store
// - store operation after stop, no acks meanwhile
// - restore runs automatically at power-up
// - acknowledged address signals ready
// - ack holds data low, nack leaves high
module ccs_ctrl #(
  parameter int         NOUT    = 6,
  parameter int         REG_AW  = 8,
  parameter logic [7:0] ID_BYTE = ccs_pkg::ID_BYTE_RESET
) (
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  input  wire logic            i_scl,
  input  wire logic            i_sda,
  input  wire logic [2:0]      i_config_select,
  input  wire logic            i_source_switch_input,
  input  wire logic            i_shutdown_output_enable_pin,
  input  wire logic            i_primary_lost,
  output logic                 o_sda_out,
  output logic                 o_sda_oe_n,
  output logic                 o_nvm_busy,
  output logic [2:0]           o_config_index,
  output logic                 o_crystal_bypass,
  output logic                 o_ref_secondary,
  output logic                 o_ref_external,
  output logic                 o_pll_shutdown,
  output logic [NOUT-1:0]      o_clock_output_oe_n,
  output logic [NOUT-1:0]      o_clock_output_suspend
);

  localparam int DEPTH = 2 ** REG_AW;

  // =====================================================================
  // pin synchronisers (system clock)
  // =====================================================================
  logic [7:0]             pin_m_q;
  logic [7:0]             pin_s_q;
  logic                   scl_p_q;
  logic                   sda_p_q;
  logic                   clr_q;
  logic                   start_w;
  logic                   stop_w;
  logic                   scl_s;
  logic                   sda_s;
  logic [2:0]             sel_s;
  logic                   sw_s;
  logic                   pin_s;
  logic                   lost_s;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_m_q <= 8'h00;
      pin_s_q <= 8'h00;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      pin_m_q <= {i_scl, i_sda, i_config_select, i_source_switch_input,
                  i_shutdown_output_enable_pin, i_primary_lost};
      pin_s_q <= pin_m_q;
      scl_p_q <= pin_s_q[7];
      sda_p_q <= pin_s_q[6];
    end
  end

  assign {scl_s, sda_s, sel_s, sw_s, pin_s, lost_s} = pin_s_q;
  assign start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_w  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // frame edges clear the link logic asynchronously; scl is high then,
  // so release lands well ahead of the next link clock edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) clr_q <= 1'b0;
    else          clr_q <= start_w | stop_w;
  end

  // =====================================================================
  // link side (serial clock)
  // =====================================================================
  logic                   lrst_n;
  logic                   busy_m_q;
  logic                   busy_s_q;
  logic [3:0]             bit_q;
  logic [7:0]             shift_q;
  logic [7:0]             rx_w;
  logic [7:0]             tx_q;
  logic                   ack_q;
  ccs_pkg::ccs_phase_e    phase_q;
  ccs_pkg::ccs_evt_s      evt_q;
  logic                   evt_tgl_q;
  logic [7:0]             rd_data_q;

  assign lrst_n = i_rst_n & ~clr_q;
  assign rx_w   = {shift_q[6:0], i_sda};

  always_ff @(posedge i_scl or negedge lrst_n) begin
    if (!lrst_n) begin
      busy_m_q <= 1'b1;
      busy_s_q <= 1'b1;
    end else begin
      busy_m_q <= o_nvm_busy;
      busy_s_q <= busy_m_q;
    end
  end

  always_ff @(posedge i_scl or negedge lrst_n) begin
    if (!lrst_n) begin
      bit_q   <= 4'h0;
      shift_q <= 8'h00;
    end else begin
      shift_q <= rx_w;
      bit_q   <= (bit_q == ccs_pkg::BIT_ACK) ? 4'h0 : bit_q + 4'h1;
    end
  end

  always_ff @(posedge i_scl or negedge lrst_n) begin
    if (!lrst_n) begin
      phase_q   <= ccs_pkg::PH_ADDR;
      ack_q     <= 1'b0;
      evt_q     <= '0;
      evt_tgl_q <= 1'b0;
      tx_q      <= 8'hff;
    end else if (bit_q == ccs_pkg::BIT_LAST) begin
      ack_q <= 1'b0;
      case (phase_q)
        ccs_pkg::PH_ADDR: begin
          // no ack while the store runs: silence is the busy sign
          if (rx_w[7:1] == ccs_pkg::SLAVE_ADDR && !busy_s_q) begin
            ack_q   <= 1'b1;
            phase_q <= rx_w[0] ? ccs_pkg::PH_RDATA : ccs_pkg::PH_CMD;
            if (rx_w[0]) begin
              evt_q     <= '{kind: ccs_pkg::PH_ADDR, data: rx_w};
              evt_tgl_q <= ~evt_tgl_q;
            end
          end else begin
            phase_q <= ccs_pkg::PH_IGNORE;
          end
        end
        ccs_pkg::PH_CMD: begin
          ack_q     <= 1'b1;
          phase_q   <= (rx_w[1:0] == ccs_pkg::CMD_WRITE) ?
                       ccs_pkg::PH_REG : ccs_pkg::PH_HOLD;
          evt_q     <= '{kind: phase_q, data: rx_w};
          evt_tgl_q <= ~evt_tgl_q;
        end
        ccs_pkg::PH_REG, ccs_pkg::PH_WDATA: begin
          ack_q     <= 1'b1;
          phase_q   <= ccs_pkg::PH_WDATA;
          evt_q     <= '{kind: phase_q, data: rx_w};
          evt_tgl_q <= ~evt_tgl_q;
        end
        ccs_pkg::PH_RDATA: begin
          evt_q     <= '{kind: phase_q, data: rx_w};
          evt_tgl_q <= ~evt_tgl_q;
        end
        default: ;
      endcase
    end else if (bit_q == ccs_pkg::BIT_ACK) begin
      tx_q <= rd_data_q;
      if (phase_q == ccs_pkg::PH_RDATA && i_sda) begin
        phase_q <= ccs_pkg::PH_IGNORE;
      end
    end
  end

  // drive on the falling edge so data is set up before the next rise
  always_ff @(negedge i_scl or negedge lrst_n) begin
    if (!lrst_n) begin
      o_sda_oe_n <= 1'b1;
    end else begin
      o_sda_oe_n <= !((bit_q == ccs_pkg::BIT_ACK && ack_q) ||
                      (phase_q == ccs_pkg::PH_RDATA && bit_q != ccs_pkg::BIT_ACK &&
                       !tx_q[3'(4'h7 - bit_q)]));
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_sda_out <= 1'b0;
    else          o_sda_out <= 1'b0;
  end

  // =====================================================================
  // byte events into the system clock
  // =====================================================================
  logic [2:0]             tgl_q;
  logic                   fire_w;
  ccs_pkg::ccs_phase_e    kind_w;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) tgl_q <= 3'h0;
    else          tgl_q <= {tgl_q[1:0], evt_tgl_q};
  end

  // evt_q settled long before the toggle arrives and holds a full byte
  assign fire_w = tgl_q[2] ^ tgl_q[1];
  assign kind_w = evt_q.kind;

  // =====================================================================
  // register file, store and pointer
  // =====================================================================
  logic [7:0]             regs_q [DEPTH];
  logic [7:0]             nvm_q  [DEPTH];
  logic [REG_AW-1:0]      ptr_q;
  logic [REG_AW-1:0]      idx_q;
  logic                   first_q;
  ccs_pkg::ccs_nvm_e      nv_q;
  ccs_pkg::ccs_nvm_e      pend_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= ccs_pkg::NV_IDLE;
    end else if (fire_w && kind_w == ccs_pkg::PH_CMD) begin
      case (evt_q.data[1:0])
        ccs_pkg::CMD_SAVE:    pend_q <= ccs_pkg::NV_SAVE;
        ccs_pkg::CMD_RESTORE: pend_q <= ccs_pkg::NV_RESTORE;
        default:              pend_q <= ccs_pkg::NV_IDLE;
      endcase
    end else if (start_w || stop_w) begin
      pend_q <= ccs_pkg::NV_IDLE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nv_q       <= ccs_pkg::NV_RESTORE;
      idx_q      <= '0;
      o_nvm_busy <= 1'b1;
    end else begin
      case (nv_q)
        ccs_pkg::NV_IDLE: begin
          if (stop_w && pend_q != ccs_pkg::NV_IDLE) begin
            nv_q       <= pend_q;
            idx_q      <= '0;
            o_nvm_busy <= 1'b1;
          end
        end
        ccs_pkg::NV_SAVE, ccs_pkg::NV_RESTORE: begin
          idx_q <= idx_q + 1'b1;
          if (&idx_q) begin
            nv_q       <= ccs_pkg::NV_IDLE;
            o_nvm_busy <= 1'b0;
          end
        end
        default: nv_q <= ccs_pkg::NV_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      regs_q <= '{default: ccs_pkg::REG_RESET};
      nvm_q  <= '{default: ccs_pkg::REG_RESET};
    end else if (nv_q == ccs_pkg::NV_RESTORE) begin
      regs_q[idx_q] <= nvm_q[idx_q];
    end else if (nv_q == ccs_pkg::NV_SAVE) begin
      nvm_q[idx_q] <= regs_q[idx_q];
    end else if (fire_w && kind_w == ccs_pkg::PH_WDATA) begin
      regs_q[ptr_q] <= evt_q.data;
    end
  end

  // read data is fetched one byte ahead so the link can latch it at ack
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_q     <= '0;
      rd_data_q <= 8'hff;
      first_q   <= 1'b0;
    end else if (fire_w) begin
      case (kind_w)
        ccs_pkg::PH_ADDR: begin
          rd_data_q <= ID_BYTE;
          first_q   <= 1'b1;
        end
        ccs_pkg::PH_REG:   ptr_q <= evt_q.data[REG_AW-1:0];
        ccs_pkg::PH_WDATA: ptr_q <= ptr_q + 1'b1;
        ccs_pkg::PH_RDATA: begin
          // the id byte uses no register, so it must not advance the pointer
          first_q <= 1'b0;
          if (first_q) begin
            rd_data_q <= regs_q[ptr_q];
          end else begin
            rd_data_q <= regs_q[REG_AW'(ptr_q + 1'b1)];
            ptr_q     <= ptr_q + 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // =====================================================================
  // configuration and output control
  // =====================================================================
  ccs_pkg::ccs_cfg_s      cfg_w;
  logic                   sp_w;
  logic [7:0]             active_w;
  logic [7:0]             gate_w;
  logic                   auto_sec_q;
  logic                   src_w;
  logic                   susp_pin_w;
  logic                   global_w;

  assign cfg_w      = ccs_pkg::ccs_cfg_s'(regs_q[REG_AW'(ccs_pkg::REG_CFG_BASE +
                                                  {5'h00, o_config_index})]);
  assign sp_w       = regs_q[REG_AW'(ccs_pkg::REG_POLARITY)][ccs_pkg::POLARITY_BIT];
  assign active_w   = regs_q[REG_AW'(ccs_pkg::REG_OUT_ACTIVE)];
  assign gate_w     = regs_q[REG_AW'(ccs_pkg::REG_OUT_GATE)];
  assign susp_pin_w = sp_w ? ~pin_s : pin_s;
  assign global_w   = cfg_w.shutdown_function & pin_s;
  assign src_w      = cfg_w.switchover_mode[1] ? auto_sec_q : sw_s;

  // reserved selections keep the last valid set in force
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)                          o_config_index <= 3'h0;
    else if (sel_s < ccs_pkg::NUM_CONFIGS) o_config_index <= sel_s;
  end

  // automatic switching has no loss detector here: i_primary_lost stands in
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      auto_sec_q <= 1'b0;
    end else if (!cfg_w.switchover_mode[1]) begin
      auto_sec_q <= 1'b0;
    end else if (lost_s) begin
      auto_sec_q <= 1'b1;
    end else if (cfg_w.switchover_mode == ccs_pkg::MODE_REVERT) begin
      auto_sec_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_crystal_bypass       <= 1'b0;
      o_ref_secondary        <= 1'b0;
      o_ref_external         <= 1'b0;
      o_pll_shutdown         <= 1'b0;
      o_clock_output_oe_n    <= '1;
      o_clock_output_suspend <= '0;
    end else begin
      o_crystal_bypass <= cfg_w.crystal_bypass;
      o_ref_secondary  <= src_w;
      o_ref_external   <= src_w ^ cfg_w.primary_source_select;
      o_pll_shutdown   <= global_w;
      for (int i = 0; i < NOUT; i++) begin
        o_clock_output_oe_n[i]    <= !active_w[i] && !global_w;
        o_clock_output_suspend[i] <= global_w ||
                                     (active_w[i] && gate_w[i] && susp_pin_w);
      end
    end
  end

  // =====================================================================
  // checks
  // =====================================================================
  property p_cfg_sel;
    @(posedge i_clk) disable iff (!i_rst_n)
      sel_s < ccs_pkg::NUM_CONFIGS |=> o_config_index == $past(sel_s);
  endproperty
  a_cfg_sel: assert property (p_cfg_sel) else $error("config index wrong");

  property p_reserved_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      sel_s >= ccs_pkg::NUM_CONFIGS |=> $stable(o_config_index);
  endproperty
  a_reserved_hold: assert property (p_reserved_hold) else $error("reserved moved set");

  property p_ref;
    @(posedge i_clk) disable iff (!i_rst_n)
      !cfg_w.switchover_mode[1] && $stable(sw_s) && $stable(cfg_w)
      |=> o_ref_external == ($past(sw_s) ^ $past(cfg_w.primary_source_select));
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");

  property p_hiz;
    @(posedge i_clk) disable iff (!i_rst_n)
      !active_w[0] && !global_w |=> o_clock_output_oe_n[0] && !o_clock_output_suspend[0];
  endproperty
  a_hiz: assert property (p_hiz) else $error("inactive output driven");

  property p_gate_pol;
    @(posedge i_clk) disable iff (!i_rst_n)
      active_w[2] && gate_w[2] && !global_w && (pin_s == sp_w)
      |=> !o_clock_output_suspend[2];
  endproperty
  a_gate_pol: assert property (p_gate_pol) else $error("polarity misread");

  property p_global;
    @(posedge i_clk) disable iff (!i_rst_n)
      cfg_w.shutdown_function && pin_s |=> o_pll_shutdown && (&o_clock_output_suspend);
  endproperty
  a_global: assert property (p_global) else $error("global shutdown missed");

  property p_nv_start;
    @(posedge i_clk) disable iff (!i_rst_n)
      nv_q == ccs_pkg::NV_IDLE && stop_w && pend_q == ccs_pkg::NV_SAVE
      |=> nv_q == ccs_pkg::NV_SAVE && o_nvm_busy;
  endproperty
  a_nv_start: assert property (p_nv_start) else $error("save not started");

  property p_restore_copy;
    @(posedge i_clk) disable iff (!i_rst_n)
      nv_q == ccs_pkg::NV_RESTORE |=> regs_q[$past(idx_q)] == $past(nvm_q[idx_q]);
  endproperty
  a_restore_copy: assert property (p_restore_copy) else $error("restore copy wrong");

  property p_incr;
    @(posedge i_clk) disable iff (!i_rst_n)
      fire_w && kind_w == ccs_pkg::PH_WDATA |=> ptr_q == $past(ptr_q) + 1'b1;
  endproperty
  a_incr: assert property (p_incr) else $error("pointer not advanced");

  property p_busy_noack;
    @(posedge i_scl) disable iff (!lrst_n)
      bit_q == ccs_pkg::BIT_ACK && phase_q != ccs_pkg::PH_RDATA && !ack_q |-> o_sda_oe_n;
  endproperty
  a_busy_noack: assert property (p_busy_noack) else $error("line driven without ack");

  property p_ack_low;
    @(posedge i_scl) disable iff (!lrst_n)
      bit_q == ccs_pkg::BIT_ACK && ack_q |-> !o_sda_oe_n;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven low");

  c_save:    cover property (@(posedge i_clk) nv_q == ccs_pkg::NV_SAVE);
  c_restore: cover property (@(posedge i_clk) $rose(pend_q == ccs_pkg::NV_RESTORE));
  c_write:   cover property (@(posedge i_clk) fire_w && kind_w == ccs_pkg::PH_WDATA);
  c_read:    cover property (@(posedge i_clk) fire_w && kind_w == ccs_pkg::PH_RDATA);

endmodule

// ==== verif/ccs_i2c_master.sv ====
`timescale 1ns/100ps
// =====================================================================
// serial bus master model
// =====================================================================
module ccs_i2c_master (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // quarter of the 125 ns serial period
  localparam realtime QTR = 31.25;

  // clock stands high between frames, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // also serves as repeated start: data rises while the clock is low
  task automatic start();
    o_sda = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda = 1'b0;
    #(2*QTR) o_scl = 1'b0;
  endtask

  task automatic stop();
    #QTR o_sda = 1'b0;
    #QTR o_scl = 1'b1;
    #(2*QTR) o_sda = 1'b1;
    #(4*QTR);
  endtask

  // nine bits: eight data bits then the ack bit; ack_in 1 releases the line
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic [8:0] sh;
    sh = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      #QTR o_sda = sh[i];
      #QTR o_scl = 1'b1;
      #QTR sh[i] = i_sda;
      #QTR o_scl = 1'b0;
    end
    rx = sh[8:1];
    ack_out = sh[0];
  endtask
endmodule

// ==== verif/clockgen_config_serial_control_bench.sv ====
`timescale 1ns/100ps
module clockgen_config_serial_control_bench;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [2:0]  sel = 3'h0;
  logic        sw = 1'b0;
  logic        pin = 1'b0;
  logic        lost = 1'b0;
  logic        scl, m_sda, sda, sda_out, sda_oe_n, busy;
  logic        byp, ref_sec, ref_ext, pll_sd;
  logic [2:0]  idx;
  logic [5:0]  oe_n, susp;
  logic [47:0] cfgs = 48'h0102_0803_100c;
  logic [24:0] steps = {5'h02, 5'h17, 5'h14, 5'h0b, 5'h09};
  logic [7:0]  b;
  logic [4:0]  st;
  int          bad_count = 0;
  int          num_checks = 0;

  always #2 i_clk = ~i_clk;
  // open-drain wire with pull-up
  assign sda = m_sda & (sda_oe_n | sda_out);

  ccs_i2c_master u_ccs_i2c_master (.i_sda(sda), .o_scl(scl), .o_sda(m_sda));

  ccs_ctrl u_ccs_ctrl (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
    .i_config_select(sel), .i_source_switch_input(sw),
    .i_shutdown_output_enable_pin(pin), .i_primary_lost(lost),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_nvm_busy(busy),
    .o_config_index(idx), .o_crystal_bypass(byp), .o_ref_secondary(ref_sec),
    .o_ref_external(ref_ext), .o_pll_shutdown(pll_sd),
    .o_clock_output_oe_n(oe_n), .o_clock_output_suspend(susp));

  // =====================================================================
  // helpers
  // =====================================================================
  task automatic summarize();
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] v, input logic exp_ack);
    logic [7:0] rx;
    logic       a;
    u_ccs_i2c_master.xfer(v, 1'b1, rx, a);
    check({7'h0, a}, {7'h0, exp_ack});
  endtask

  task automatic recv(input logic [7:0] exp, input logic last);
    logic [7:0] rx;
    logic       a;
    u_ccs_i2c_master.xfer(8'hff, last, rx, a);
    check(rx, exp);
  endtask

  task automatic addr_reg(input logic [7:0] ra);
    u_ccs_i2c_master.start();
    send({ccs_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
    send({6'h0, ccs_pkg::CMD_WRITE}, 1'b0);
    send(ra, 1'b0);
  endtask

  task automatic wr(input logic [7:0] ra, input logic [47:0] d, input int n);
    addr_reg(ra);
    for (int i = n - 1; i >= 0; i--) send(d[8*i +: 8], 1'b0);
    u_ccs_i2c_master.stop();
  endtask

  // pointer set, then repeated start into the read
  task automatic rd(input logic [7:0] ra, input logic [47:0] d, input int n);
    addr_reg(ra);
    u_ccs_i2c_master.start();
    send({ccs_pkg::SLAVE_ADDR, 1'b1}, 1'b0);
    recv(ccs_pkg::ID_BYTE_RESET, 1'b0);
    for (int i = n - 1; i >= 0; i--) recv(d[8*i +: 8], i == 0);
    u_ccs_i2c_master.stop();
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge i_clk);
      k++;
    end
    check({7'h0, busy}, 8'h00);
  endtask

  task automatic nv_cmd(input logic [7:0] c);
    u_ccs_i2c_master.start();
    send({ccs_pkg::SLAVE_ADDR, 1'b0}, 1'b0);
    send(c, 1'b0);
    @(negedge i_clk);
    check({7'h0, busy}, 8'h00);
    u_ccs_i2c_master.stop();
    check({7'h0, busy}, 8'h01);
    wait_idle();
  endtask

  // pins pass two flops, outputs settle a few cycles later
  task automatic pins(input logic [2:0] s, input logic w, input logic p, input logic l);
    @(posedge i_clk);
    sel <= s;
    sw <= w;
    pin <= p;
    lost <= l;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // =====================================================================
  // tests
  // =====================================================================
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    check({7'h0, busy}, 8'h01);
    wait_idle();
    u_ccs_i2c_master.start();
    send(8'h56, 1'b1);
    send(8'h00, 1'b1);
    u_ccs_i2c_master.stop();
    for (int p = 0; p < 2; p++) begin
      wr(ccs_pkg::REG_POLARITY, {24'h0, 7'h0, p[0], 16'h3e0c}, 3);
      for (int q = 0; q < 2; q++) begin
        pins(3'h0, 1'b0, q[0], 1'b0);
        check({2'h0, oe_n}, 8'h01);
        check({2'h0, susp}, (p[0] ^ q[0]) ? 8'h0c : 8'h00);
      end
    end
    rd(ccs_pkg::REG_POLARITY, 48'h01_3e_0c, 3);
    wr(ccs_pkg::REG_CFG_BASE, cfgs, 6);
    for (int k = 0; k < 6; k++) begin
      b = cfgs[8*(5-k) +: 8];
      pins(k[2:0], 1'b0, 1'b0, 1'b0);
      check({5'h0, idx}, {5'h0, k[2:0]});
      check({7'h0, byp}, {7'h0, b[0]});
      check({7'h0, ref_ext}, {7'h0, b[1]});
      if (!b[3]) begin
        pins(k[2:0], 1'b1, 1'b0, 1'b0);
        check({7'h0, ref_ext}, {7'h0, ~b[1]});
        check({7'h0, ref_sec}, 8'h01);
      end
    end
    // manual ignores loss, auto latches, auto-revertive returns
    for (int i = 4; i >= 0; i--) begin
      st = steps[5*i +: 5];
      pins(st[4:2], 1'b0, 1'b0, st[1]);
      check({7'h0, ref_sec}, {7'h0, st[0]});
    end
    pins(3'h4, 1'b0, 1'b1, 1'b0);
    check({7'h0, pll_sd}, 8'h01);
    check({2'h0, susp}, 8'h3f);
    pins(3'h4, 1'b0, 1'b0, 1'b0);
    check({7'h0, pll_sd}, 8'h00);
    check({2'h0, susp}, 8'h0c);
    nv_cmd(8'h01);
    wr(ccs_pkg::REG_POLARITY, 48'h0, 1);
    nv_cmd(8'hf6);
    rd(ccs_pkg::REG_POLARITY, 48'h01_3e_0c, 3);
    summarize();
  end

  initial begin
    repeat (60000) @(posedge i_clk);
    bad_count++;
    summarize();
  end
endmodule
